// *** cpw_regs.vh ***
`ifndef CPW_REGS_VH
`define CPW_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define CPW_OFS_COUNT      8'h00
`define CPW_OFS_PERIOD     8'h04
`define CPW_OFS_TCTRL      8'h08
`define CPW_OFS_DUTY_HI    8'h0C
`define CPW_OFS_SHADOW     8'h10
`define CPW_OFS_CHAN_CTRL  8'h14
`define CPW_OFS_AUX        8'h18

// Base timer control fields.
`define CPW_TCTRL_PRE_LO   0
`define CPW_TCTRL_PRE_HI   1
`define CPW_TCTRL_ON       2
`define CPW_TCTRL_POST_LO  3
`define CPW_TCTRL_POST_HI  6
`define CPW_TCTRL_MASK     8'h7F

// Channel control fields.
`define CPW_CC_MODE_LO     0
`define CPW_CC_MODE_HI     3
`define CPW_CC_DLOW_LO     4
`define CPW_CC_DLOW_HI     5
`define CPW_CC_MASK        8'h3F
`define CPW_MODE_PWM_TOP   2'h3

// Auxiliary register fields.
`define CPW_AUX_DIR        0
`define CPW_AUX_POSTFLAG   1
`define CPW_AUX_MASK       8'h03

// Prescale select encodings.
`define CPW_PRE_DIV1       2'h0
`define CPW_PRE_DIV4       2'h1

// Reset values.
`define CPW_RST_COUNT      8'h00
`define CPW_RST_PERIOD     8'hFF
`define CPW_RST_TCTRL      8'h00
`define CPW_RST_DUTY_HI    8'h00
`define CPW_RST_SHADOW     8'h00
`define CPW_RST_CHAN_CTRL  8'h00
`define CPW_RST_AUX        8'h01

// Timing: oscillator cycles per base counter step at prescale one.
`define CPW_OSC_PER_STEP   4
`define CPW_PRE_WIDTH      6

// AXI responses.
`define CPW_RESP_OKAY      2'h0
`define CPW_RESP_SLVERR    2'h2

`endif

// *** cpw_prescaler.v ***
`timescale 1ns/1ps
`include "cpw_regs.vh"

module cpw_prescaler #(
    parameter WIDTH = `CPW_PRE_WIDTH
) (
    // Clock and reset.
    input  wire       i_clk,
    input  wire       i_sys_rst,
    // Control.
    input  wire       i_run,
    input  wire       i_clear,
    input  wire [1:0] i_sel,
    // Time base.
    output wire       o_tick,
    output reg  [1:0] o_low_bits
);

    reg  [WIDTH-1:0] cnt_ff;
    reg  [WIDTH-1:0] limit;

    // Terminal count for divide by one, four and sixteen, each on four oscillator steps.
    always @* begin
        case (i_sel)
            `CPW_PRE_DIV1: limit = {{(WIDTH-2){1'b0}}, 2'h3};
            `CPW_PRE_DIV4: limit = {{(WIDTH-4){1'b0}}, 4'hF};
            default:       limit = {WIDTH{1'b1}};
        endcase
    end

    // The two bits above the prescale ratio extend the base counter by a quarter step.
    always @* begin
        case (i_sel)
            `CPW_PRE_DIV1: o_low_bits = cnt_ff[1:0];
            `CPW_PRE_DIV4: o_low_bits = cnt_ff[3:2];
            default:       o_low_bits = cnt_ff[5:4];
        endcase
    end

    assign o_tick = i_run && (cnt_ff == limit);

    // Oscillator cycle counter; wraps at the terminal count.
    always @(posedge i_clk) begin
        if (i_sys_rst || i_clear) begin
            cnt_ff <= {WIDTH{1'b0}};
        end else if (i_run) begin
            if (cnt_ff == limit) begin
                cnt_ff <= {WIDTH{1'b0}};
            end else begin
                cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// *** cpw_pwm_top.v ***
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cpw_regs.vh"

module cpw_pwm_top #(
    parameter POST_WIDTH = 4
) (
    // Clock and reset.
    input  wire        i_clk,
    input  wire        i_sys_rst,
    // AXI4-Lite write address channel.
    input  wire [7:0]  i_axi_awaddr,
    input  wire        i_axi_awvalid,
    output reg         o_axi_awready,
    // AXI4-Lite write data channel.
    input  wire [31:0] i_axi_wdata,
    input  wire [3:0]  i_axi_wstrb,
    input  wire        i_axi_wvalid,
    output reg         o_axi_wready,
    // AXI4-Lite write response channel.
    output reg  [1:0]  o_axi_bresp,
    output reg         o_axi_bvalid,
    input  wire        i_axi_bready,
    // AXI4-Lite read address channel.
    input  wire [7:0]  i_axi_araddr,
    input  wire        i_axi_arvalid,
    output reg         o_axi_arready,
    // AXI4-Lite read data channel.
    output reg  [31:0] o_axi_rdata,
    output reg  [1:0]  o_axi_rresp,
    output reg         o_axi_rvalid,
    input  wire        i_axi_rready,
    // General-purpose port function sharing the pin.
    input  wire        i_port_data,
    // Output pin.
    output reg         o_pin_out,
    output reg         o_pin_oe
);

    localparam [POST_WIDTH-1:0] POST_ONE = {{(POST_WIDTH-1){1'b0}}, 1'b1};
    localparam [7:0]            AUX_RST  = `CPW_RST_AUX; // Auxiliary register reset image.

    // Register state.
    reg  [7:0]            count_ff;
    reg  [7:0]            period_ff;
    reg  [7:0]            tctrl_ff;
    reg  [7:0]            duty_hi_ff;
    reg  [7:0]            shadow_ff;
    reg  [1:0]            shadow_low_ff;
    reg  [7:0]            chan_ctrl_ff;
    reg                   dir_ff;
    reg                   post_flag_ff;
    reg  [POST_WIDTH-1:0] post_cnt_ff;
    reg                   pwm_latch_ff;
    reg                   restart_ff;

    // Bus slave state.
    reg                   aw_held_ff;
    reg  [7:0]            aw_addr_ff;
    reg                   w_held_ff;
    reg  [7:0]            w_data_ff;
    reg                   w_lane0_ff;

    // Datapath wires.
    wire                  timer_on;
    wire [1:0]            pre_sel;
    wire [3:0]            post_sel;
    wire                  pwm_mode;
    wire [9:0]            duty_value;
    wire [9:0]            shadow_value;
    wire [9:0]            time_base;
    wire                  tick;
    wire [1:0]            low_bits;
    wire                  period_match;
    wire                  period_end;
    wire                  compare_hit;
    wire                  do_write;
    wire                  wr_hit;
    reg                   wr_mapped;
    reg  [7:0]            rd_byte;
    reg                   rd_mapped;
    reg                   nxt_pin_out;

    assign timer_on   = tctrl_ff[`CPW_TCTRL_ON];
    assign pre_sel    = tctrl_ff[`CPW_TCTRL_PRE_HI:`CPW_TCTRL_PRE_LO];
    assign post_sel   = tctrl_ff[`CPW_TCTRL_POST_HI:`CPW_TCTRL_POST_LO];
    assign pwm_mode   = (chan_ctrl_ff[`CPW_CC_MODE_HI:`CPW_CC_MODE_HI-1] == `CPW_MODE_PWM_TOP);

    // Ten-bit duty word built from the high byte and the two low control bits.
    assign duty_value = {duty_hi_ff, chan_ctrl_ff[`CPW_CC_DLOW_HI:`CPW_CC_DLOW_LO]};

    // Active compare value comes only from the buffered copy.
    assign shadow_value = {shadow_ff, shadow_low_ff};

    // Counter extended by two quarter-step bits; one step of it is prescale oscillator cycles.
    assign time_base  = {count_ff, low_bits};

    assign period_match = (count_ff == period_ff);
    assign period_end   = tick && period_match;
    assign compare_hit  = (shadow_value == time_base);

    // A write goes ahead once both address and data are held.
    assign do_write = aw_held_ff && w_held_ff && !o_axi_bvalid;
    assign wr_hit   = do_write && w_lane0_ff && wr_mapped;

    // Prescaler drives the base counter with factors one, four and sixteen.
    cpw_prescaler #(
        .WIDTH      (`CPW_PRE_WIDTH)
    ) u_prescaler (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_run      (timer_on),
        .i_clear    (wr_hit && (aw_addr_ff == `CPW_OFS_COUNT)),
        .i_sel      (pre_sel),
        .o_tick     (tick),
        .o_low_bits (low_bits)
    );

    // Decode of writable offsets.
    always @* begin
        case (aw_addr_ff)
            `CPW_OFS_COUNT,
            `CPW_OFS_PERIOD,
            `CPW_OFS_TCTRL,
            `CPW_OFS_DUTY_HI,
            `CPW_OFS_SHADOW,
            `CPW_OFS_CHAN_CTRL,
            `CPW_OFS_AUX:       wr_mapped = 1'b1;
            default:            wr_mapped = 1'b0;
        endcase
    end

    // Write address capture.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            aw_held_ff    <= 1'b0;
            aw_addr_ff    <= 8'h00;
            o_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held_ff    <= 1'b0;
            o_axi_awready <= 1'b0;
        end else if (o_axi_awready && i_axi_awvalid) begin
            aw_held_ff    <= 1'b1;
            aw_addr_ff    <= i_axi_awaddr;
            o_axi_awready <= 1'b0;
        end else begin
            o_axi_awready <= !aw_held_ff && !o_axi_bvalid;
        end
    end

    // Write data capture; registers are one byte wide in lane zero.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            w_held_ff    <= 1'b0;
            w_data_ff    <= 8'h00;
            w_lane0_ff   <= 1'b0;
            o_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held_ff    <= 1'b0;
            o_axi_wready <= 1'b0;
        end else if (o_axi_wready && i_axi_wvalid) begin
            w_held_ff    <= 1'b1;
            w_data_ff    <= i_axi_wdata[7:0];
            w_lane0_ff   <= i_axi_wstrb[0];
            o_axi_wready <= 1'b0;
        end else begin
            o_axi_wready <= !w_held_ff && !o_axi_bvalid;
        end
    end

    // Write response; unmapped offsets answer with a slave error.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_axi_bvalid <= 1'b0;
            o_axi_bresp  <= `CPW_RESP_OKAY;
        end else if (do_write) begin
            o_axi_bvalid <= 1'b1;
            o_axi_bresp  <= wr_mapped ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
        end else if (i_axi_bready) begin
            o_axi_bvalid <= 1'b0;
        end
    end

    // Software-only registers; duty sources take writes at any moment.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            period_ff    <= `CPW_RST_PERIOD;
            tctrl_ff     <= `CPW_RST_TCTRL;
            duty_hi_ff   <= `CPW_RST_DUTY_HI;
            chan_ctrl_ff <= `CPW_RST_CHAN_CTRL;
            dir_ff       <= AUX_RST[`CPW_AUX_DIR];
        end else if (wr_hit) begin
            case (aw_addr_ff)
                `CPW_OFS_PERIOD:    period_ff    <= w_data_ff;
                `CPW_OFS_TCTRL:     tctrl_ff     <= w_data_ff & `CPW_TCTRL_MASK;
                `CPW_OFS_DUTY_HI:   duty_hi_ff   <= w_data_ff;
                `CPW_OFS_CHAN_CTRL: chan_ctrl_ff <= w_data_ff & `CPW_CC_MASK;
                `CPW_OFS_AUX:       dir_ff       <= w_data_ff[`CPW_AUX_DIR];
                default:            dir_ff       <= dir_ff;
            endcase
        end
    end

    // Base counter: clears on the step after it equals the period.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_ff <= `CPW_RST_COUNT;
        end else if (wr_hit && (aw_addr_ff == `CPW_OFS_COUNT)) begin
            count_ff <= w_data_ff;
        end else if (period_end) begin
            count_ff <= 8'h00;
        end else if (tick) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // Shadow load at period end; software may write it only outside PWM mode.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            shadow_ff     <= `CPW_RST_SHADOW;
            shadow_low_ff <= 2'h0;
        end else if (period_end) begin
            {shadow_ff, shadow_low_ff} <= duty_value;
        end else if (wr_hit && (aw_addr_ff == `CPW_OFS_SHADOW) && !pwm_mode) begin
            shadow_ff     <= w_data_ff;
        end
    end

    // Postscaler counts period matches and raises a sticky flag; the PWM never sees it.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            post_cnt_ff  <= {POST_WIDTH{1'b0}};
            post_flag_ff <= 1'b0;
        end else begin
            if (period_end) begin
                if (post_cnt_ff == post_sel[POST_WIDTH-1:0]) begin
                    post_cnt_ff  <= {POST_WIDTH{1'b0}};
                    post_flag_ff <= 1'b1;
                end else begin
                    post_cnt_ff  <= post_cnt_ff + POST_ONE;
                end
            end
            if (wr_hit && (aw_addr_ff == `CPW_OFS_AUX) && w_data_ff[`CPW_AUX_POSTFLAG]
                && !(period_end && (post_cnt_ff == post_sel[POST_WIDTH-1:0]))) begin
                post_flag_ff <= 1'b0;
            end
        end
    end

    // Restart marker one clock after the period match, when the shadow holds the new duty.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= period_end;
        end
    end

    // Output latch: set one clock after the restart so the high time is exactly duty steps
    // of the time base, since the clear also lands one clock after the compare match.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwm_latch_ff <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_latch_ff <= 1'b0;
        end else if (restart_ff) begin
            pwm_latch_ff <= (shadow_value != 10'h000);
        end else if (compare_hit) begin
            pwm_latch_ff <= 1'b0;
        end
    end

    // Pin mux selects the channel only in PWM mode.
    always @* begin
        if (pwm_mode) begin
            nxt_pin_out = pwm_latch_ff;
        end else begin
            nxt_pin_out = i_port_data;
        end
    end

    // Registered pin drive; direction bit low makes the pin an output.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b0;
        end else begin
            o_pin_out <= nxt_pin_out;
            o_pin_oe  <= !dir_ff;
        end
    end

    // Read decode; unimplemented bits return zero.
    always @* begin
        rd_mapped = 1'b1;
        case (i_axi_araddr)
            `CPW_OFS_COUNT:     rd_byte = count_ff;
            `CPW_OFS_PERIOD:    rd_byte = period_ff;
            `CPW_OFS_TCTRL:     rd_byte = tctrl_ff & `CPW_TCTRL_MASK;
            `CPW_OFS_DUTY_HI:   rd_byte = duty_hi_ff;
            `CPW_OFS_SHADOW:    rd_byte = shadow_ff;
            `CPW_OFS_CHAN_CTRL: rd_byte = chan_ctrl_ff & `CPW_CC_MASK;
            `CPW_OFS_AUX:       rd_byte = {6'h00, post_flag_ff, dir_ff};
            default: begin
                rd_byte   = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

    // Read channel: address taken when idle, data one cycle later.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h00000000;
            o_axi_rresp   <= `CPW_RESP_OKAY;
        end else if (o_axi_arready && i_axi_arvalid) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b1;
            o_axi_rdata   <= {24'h000000, rd_byte};
            o_axi_rresp   <= rd_mapped ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
        end else if (o_axi_rvalid) begin
            if (i_axi_rready) begin
                o_axi_rvalid <= 1'b0;
            end
        end else begin
            o_axi_arready <= 1'b1;
        end
    end

endmodule

// *** cpw_pwm_chk.sv ***
`timescale 1ns/1ps

module cpw_pwm_chk (
    // Clock and reset.
    input wire        i_clk,
    input wire        i_sys_rst,
    // Bus handshakes.
    input wire        i_axi_awvalid,
    input wire        o_axi_awready,
    input wire        i_axi_wvalid,
    input wire        o_axi_wready,
    input wire [1:0]  o_axi_bresp,
    input wire        o_axi_bvalid,
    input wire        i_axi_bready,
    input wire        i_axi_arvalid,
    input wire        o_axi_arready,
    input wire [31:0] o_axi_rdata,
    input wire [1:0]  o_axi_rresp,
    input wire        o_axi_rvalid,
    input wire        i_axi_rready,
    // Pin.
    input wire        o_pin_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Answers stand unchanged until the master takes them.
    a_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=>
        o_axi_bvalid && $stable(o_axi_bresp)) else $error("write answer moved early");
    a_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=>
        o_axi_rvalid && $stable(o_axi_rdata)) else $error("read answer moved early");
    // Answers follow the accepted request within the stated latency.
    a_b_latency: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid
        && o_axi_wready |-> ##[1:2] o_axi_bvalid) else $error("write answer late");
    a_r_latency: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
        else $error("read answer late");
    // Only the low byte carries register data.
    a_rdata_upper: assert property (o_axi_rvalid |-> o_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    // No new request is taken while an answer stands; the write address reopens two clocks after the answer is taken.
    a_w_block: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("write taken during answer");
    a_ar_block: assert property (o_axi_rvalid |-> !o_axi_arready)
        else $error("read taken during answer");
    a_aw_reopen: assert property (o_axi_bvalid && i_axi_bready |-> ##2 o_axi_awready)
        else $error("write address not reopened");

    // Main scenarios.
    c_write: cover property (o_axi_bvalid && i_axi_bready);
    c_err: cover property (o_axi_rvalid && o_axi_rresp == 2'h2);
    c_pin: cover property ($rose(o_pin_out));
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "cpw_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

bind cpw_pwm_top cpw_pwm_chk chk_u (.i_clk, .i_sys_rst, .i_axi_awvalid, .o_axi_awready,
    .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready, .i_axi_arvalid,
    .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .o_pin_out);

module tb;
    reg          i_clk, i_sys_rst, i_port_data;
    reg  [7:0]   i_axi_awaddr, i_axi_araddr;
    reg  [31:0]  i_axi_wdata;
    reg  [3:0]   i_axi_wstrb;
    reg          i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready;
    wire         o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
    wire [1:0]   o_axi_bresp, o_axi_rresp;
    wire [31:0]  o_axi_rdata;
    wire         o_pin_out, o_pin_oe;
    integer      failures = 0, n_tests = 0, cyc = 0, seed = 32'h327bfd49, s, d;
    reg  [33:0]  qe[$], qm[$], e_q, m_q, g_q;

    cpw_pwm_top dut_u (.i_clk, .i_sys_rst, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready,
        .i_axi_wdata, .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
        .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata,
        .o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .i_port_data, .o_pin_out, .o_pin_oe);

    // Free-running 20 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Prints the verdict and stops the run.
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask

    // Takes the oldest expectation whenever an answer is handed over; cuts a hang short.
    always @(posedge i_clk) begin
        if ((o_axi_rvalid && i_axi_rready) || (o_axi_bvalid && i_axi_bready)) begin
            e_q = qe.pop_front();
            m_q = qm.pop_front();
            g_q = o_axi_rvalid ? {o_axi_rresp, o_axi_rdata} : {o_axi_bresp, 32'h0};
            `CHK(g_q & m_q, e_q & m_q)
        end
        cyc = cyc + 1;
        if (cyc > 60000) begin
            failures++;
            complete_run;
        end
    end

    // One write; both halves offered together and released as each is taken.
    task wr(input [7:0] a, input [7:0] v, input [3:0] st, input [1:0] rsp);
        reg aw, w, b;
        reg [31:0] r;
        begin
            @(posedge i_clk);
            r = $random(seed);
            qe.push_back({rsp, 32'h0});
            qm.push_back({2'h3, 32'h0});
            i_axi_awaddr <= a;
            i_axi_wdata <= {r[23:0], v};
            i_axi_wstrb <= st;
            i_axi_awvalid <= 1'b1;
            i_axi_wvalid <= 1'b1;
            i_axi_bready <= 1'b1;
            aw = 1; w = 1; b = 1;
            while (aw || w || b) begin
                @(posedge i_clk);
                if (aw && o_axi_awready) begin aw = 0; i_axi_awvalid <= 1'b0; end
                if (w && o_axi_wready) begin w = 0; i_axi_wvalid <= 1'b0; end
                if (b && o_axi_bvalid) begin b = 0; i_axi_bready <= 1'b0; end
            end
        end
    endtask

    // One read with an expected word, a compare mask and a response code.
    task rd(input [7:0] a, input [31:0] x, input [31:0] m, input [1:0] rsp);
        reg ar, r;
        begin
            @(posedge i_clk);
            qe.push_back({rsp, x});
            qm.push_back({2'h3, m});
            i_axi_araddr <= a;
            i_axi_arvalid <= 1'b1;
            i_axi_rready <= 1'b1;
            ar = 1; r = 1;
            while (ar || r) begin
                @(posedge i_clk);
                if (ar && o_axi_arready) begin ar = 0; i_axi_arvalid <= 1'b0; end
                if (r && o_axi_rvalid) begin r = 0; i_axi_rready <= 1'b0; end
            end
        end
    endtask

    task w8(input [7:0] a, input [7:0] v);
        wr(a, v, 4'h1, `CPW_RESP_OKAY);
    endtask

    task r8(input [7:0] a, input [7:0] v);
        rd(a, {24'h0, v}, 32'hFFFFFFFF, `CPW_RESP_OKAY);
    endtask

    // Counts cycles while the pin holds a level, up to a limit.
    task run_lvl(input v, input integer mx, output integer n);
        begin
            n = 0;
            while (o_pin_out === v && n < mx) begin
                @(posedge i_clk);
                n++;
            end
        end
    endtask

    // Sets up one waveform in the documented order and measures it.
    task pw(input [7:0] p, input [9:0] dv, input [1:0] ps);
        integer f, per, n, m;
        reg [31:0] r;
        begin
            w8(`CPW_OFS_CHAN_CTRL, 8'h00);
            @(posedge i_clk);
            `CHK(o_pin_out, 1'b0)
            w8(`CPW_OFS_TCTRL, 8'h00);
            w8(`CPW_OFS_COUNT, 8'h00);
            f = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
            per = (p + 1) * 4 * f;
            r = $random(seed);
            w8(`CPW_OFS_PERIOD, p);
            w8(`CPW_OFS_DUTY_HI, dv[9:2]);
            w8(`CPW_OFS_CHAN_CTRL, {2'h0, dv[1:0], 4'h0});
            w8(`CPW_OFS_AUX, 8'h00);
            w8(`CPW_OFS_TCTRL, {1'b0, r[3:0], 1'b0, ps});
            w8(`CPW_OFS_TCTRL, {1'b0, r[3:0], 1'b1, ps});
            w8(`CPW_OFS_CHAN_CTRL, {2'h0, dv[1:0], 4'hC});
            run_lvl(1'b0, per * 2, n);
            if (dv == 0) `CHK(n, per * 2)
            else begin
                run_lvl(1'b1, per * 2, n);
                if (dv > p * 4 + 3) `CHK(n, per * 2)
                else begin
                    `CHK(n, dv * f)
                    run_lvl(1'b0, per, m);
                    `CHK(n + m, per)
                end
            end
            $display("waveform test done p=%h d=%h s=%0d", p, dv, ps);
        end
    endtask

    // Main sequence.
    initial begin
        {i_port_data, i_axi_awaddr, i_axi_araddr, i_axi_wdata, i_axi_wstrb} = 0;
        {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = 0;
        i_sys_rst = 1'b1;
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        r8(`CPW_OFS_COUNT, `CPW_RST_COUNT);
        r8(`CPW_OFS_PERIOD, `CPW_RST_PERIOD);
        r8(`CPW_OFS_TCTRL, `CPW_RST_TCTRL);
        r8(`CPW_OFS_DUTY_HI, `CPW_RST_DUTY_HI);
        r8(`CPW_OFS_SHADOW, `CPW_RST_SHADOW);
        r8(`CPW_OFS_CHAN_CTRL, `CPW_RST_CHAN_CTRL);
        r8(`CPW_OFS_AUX, `CPW_RST_AUX);
        rd(8'h1C, 32'h0, 32'h0, `CPW_RESP_SLVERR);
        wr(8'h1C, 8'h55, 4'h1, `CPW_RESP_SLVERR);
        w8(`CPW_OFS_TCTRL, 8'hFF);
        r8(`CPW_OFS_TCTRL, `CPW_TCTRL_MASK);
        w8(`CPW_OFS_CHAN_CTRL, 8'hFF);
        r8(`CPW_OFS_CHAN_CTRL, `CPW_CC_MASK);
        w8(`CPW_OFS_CHAN_CTRL, 8'h00);
        w8(`CPW_OFS_TCTRL, 8'h00);
        wr(`CPW_OFS_DUTY_HI, 8'h77, 4'h0, `CPW_RESP_OKAY);
        r8(`CPW_OFS_DUTY_HI, 8'h00);
        i_port_data <= 1'b1;
        w8(`CPW_OFS_AUX, 8'h00);
        repeat (2) @(posedge i_clk);
        `CHK({o_pin_out, o_pin_oe}, 2'b11)
        i_port_data <= 1'b0;
        $display("register test done");
        for (s = 0; s < 4; s++) begin
            d = 1 + ({$random(seed)} % 31);
            pw(8'h07, d[9:0], s[1:0]);
        end
        pw(8'h07, 10'h3FF, 2'h0);
        pw(8'h07, 10'h000, 2'h1);
        pw(8'h3F, 10'h080, 2'h2);
        w8(`CPW_OFS_SHADOW, 8'hA5);
        r8(`CPW_OFS_SHADOW, 8'h20);
        w8(`CPW_OFS_DUTY_HI, 8'h30);
        r8(`CPW_OFS_SHADOW, 8'h20);
        repeat (4096) @(posedge i_clk);
        r8(`CPW_OFS_SHADOW, 8'h30);
        w8(`CPW_OFS_CHAN_CTRL, 8'h00);
        w8(`CPW_OFS_SHADOW, 8'h5A);
        r8(`CPW_OFS_SHADOW, 8'h5A);
        $display("shadow test done");
        repeat (4) @(posedge i_clk);
        complete_run;
    end
endmodule
